// *** inc/dcp_pkg.sv ***
/*
  Constants shared by the disk controller CPU port: command field
  codes, status word bit positions, ECC codes, register offsets and
  timing figures.
  Assumes a single 40 MHz clock domain.
*/
`default_nettype none

package dcp_pkg;

  ////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS  = 25;   // MCLK period
  localparam int MICROCYCLE_NS  = 270;  // Processor microcycle
  localparam int PHASE2_NS      = 90;   // Phase-2 high window
  // Longest windows round down to whole cycles
  localparam int MICROCYCLE_CYC = MICROCYCLE_NS / CLK_PERIOD_NS;
  localparam int PHASE2_CYC     = PHASE2_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////
  // Command identity and command bits
  localparam logic [1:0] ID_READ  = 2'h0;
  localparam logic [1:0] ID_WRITE = 2'h1;
  localparam logic [1:0] ID_CTRL  = 2'h2;
  localparam logic [1:0] ID_NOP   = 2'h3;
  localparam logic [2:0] RD_STAT  = 3'h0;
  localparam logic [2:0] RD_ADDR  = 3'h1;
  localparam logic [2:0] RD_BYTE  = 3'h2;
  localparam logic [2:0] RD_WORD  = 3'h3;
  localparam logic [2:0] RD_PAT   = 3'h4;
  localparam logic [2:0] RD_POS   = 3'h5;
  localparam logic [2:0] CT_CLRBF = 3'h0;
  localparam logic [2:0] CT_CLRALL = 3'h3;

  ////////////////////////////////////////////////////////////////////
  // Status word bit positions
  localparam int SW_OPINC = 10;
  localparam int SW_DCHK  = 11;
  localparam int SW_DLATE = 12;
  localparam int SW_DRVE  = 14;
  localparam int SW_COMP  = 15;
  localparam int SW_ECCHI = 20;
  localparam int SW_ECCLO = 21;

  // ECC comparison codes, hi bit first
  localparam logic [1:0] ECC_NONE  = 2'h0;
  localparam logic [1:0] ECC_DATA  = 2'h1;
  localparam logic [1:0] ECC_NCORR = 2'h2;
  localparam logic [1:0] ECC_CORR  = 2'h3;

  ////////////////////////////////////////////////////////////////////
  // Register port
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_STAT  = 4'h4;
  localparam int         CTRL_FIX  = 0;    // Fixed drive selected
  localparam logic       CTRL_RST  = 1'b0;

endpackage : dcp_pkg

`default_nettype wire

// *** hdl/dcp_cpu_port.sv ***
/*
  CPU side port of the disk controller: decodes port commands, keeps
  the error and ECC status, captures drive status bytes and answers
  read strobes. Also a small register port for software.
  Assumes all inputs synchronous to MCLK and the package dcp_pkg.
*/
// Strobed register access and the placing of the registers were chosen for this implementation.
`default_nettype none

module dcp_cpu_port (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        CMD_STROBE,
  input  wire logic        DEV_SELECT_BIT,
  input  wire logic [4:0]  CMD_FIELD,
  input  wire logic        GATED_PHASE2_CLK,
  input  wire logic        READ_PORT,
  input  wire logic        ACCEL_SELECT,
  output logic      [31:0] CPU_RDATA,
  output logic             CPU_RDATA_OE,
  input  wire logic        EV_DATA_ECC,
  input  wire logic        EV_HDR_ECC,
  input  wire logic        EV_TIMEOUT,
  input  wire logic        EV_HDR_MISSING,
  input  wire logic        EV_BUF_LATE,
  input  wire logic        EV_DRIVE_ERR,
  input  wire logic        ECC_DONE,
  input  wire logic        ECC_ANY_ERR,
  input  wire logic        ECC_NONCORR,
  input  wire logic        ECC_CORR,
  input  wire logic [31:0] DISK_ADDR,
  input  wire logic [31:0] BUF_WORD,
  input  wire logic [12:0] ERR_PATTERN,
  input  wire logic [12:0] ERR_POSITION,
  input  wire logic        STATUS_SAMPLE,
  input  wire logic [2:0]  CART_STATE,
  input  wire logic        BRUSHES_HOME,
  input  wire logic        HEADS_OUT,
  input  wire logic        COVER_OPEN,
  input  wire logic        HEAD_SEL,
  input  wire logic        MULTI_SELECT_ERR,
  input  wire logic        VOLUME_CHANGED,
  input  wire logic        WRITE_GATE_ERR,
  input  wire logic        SPINDLE_ERR,
  input  wire logic        SEEK_TIMEOUT,
  input  wire logic        WRITE_LOCKED,
  input  wire logic        STRAY_WRITE_CURRENT,
  input  wire logic        WRITE_DATA_MISSING,
  input  wire logic [4:0]  SECTOR_COUNT,
  input  wire logic        DRIVE_FAULT,
  input  wire logic        ADDR_PLUG_VALID,
  input  wire logic        SEEK_ERR,
  input  wire logic        ON_CYLINDER,
  input  wire logic        DRIVE_READY,
  input  wire logic        WRITE_PROTECTED,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic        p2_q_ff;      // Phase-2 one cycle ago
  logic        cmd_take;     // Command accepted this cycle
  logic [1:0]  cmd_id;       // Identity pair
  logic [2:0]  cmd_op;       // Command bits
  logic        rd_cmd;       // Read command taken
  logic        clr_all;      // Clear-all control taken
  logic        clr_ptr;      // Byte pointer clear
  logic [5:0]  ev;           // Error events this cycle
  logic [5:0]  flg_ff;       // Sticky error events
  logic [1:0]  ecc_ff;       // Latched ECC code
  logic [1:0]  nxt_ecc;      // Encoded ECC code
  logic [7:0]  cart0_ff;     // Cartridge status byte one
  logic [7:0]  cart1_ff;     // Cartridge status byte two
  logic [7:0]  fix0_ff;      // Fixed drive status byte one
  logic [7:0]  fix1_ff;      // Fixed drive status byte two
  logic        byte_ptr_ff;  // Next status byte to hand out
  logic        fixed_ff;     // Drive type select
  logic [31:0] stat_word;    // Assembled status word
  logic [31:0] word_ff;      // Word staged by last read command
  logic [31:0] nxt_word;     // Word selected by read command
  logic        rd_req;       // Read strobe meant for this port
  logic [4:0]  err5;         // Error bits for checking

  ////////////////////////////////////////////////////////////////////
  // Command decode
  // Phase-2 edge picks one cycle per microcycle, since the strobe
  // stands for several MCLK cycles
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      p2_q_ff <= 1'b0;
    else
      p2_q_ff <= GATED_PHASE2_CLK;
  end

  assign cmd_id = CMD_FIELD[4:3];
  assign cmd_op = CMD_FIELD[2:0];
  // Strobe and select in the same cycle, else ignored
  assign cmd_take = CMD_STROBE & DEV_SELECT_BIT
                  & GATED_PHASE2_CLK & ~p2_q_ff;
  // Identity 11 matches none of these decodes
  assign rd_cmd  = cmd_take & (cmd_id == dcp_pkg::ID_READ);
  assign clr_all = cmd_take & (cmd_id == dcp_pkg::ID_CTRL)
                 & (cmd_op == dcp_pkg::CT_CLRALL);
  assign clr_ptr = clr_all | (cmd_take & (cmd_id == dcp_pkg::ID_CTRL)
                 & (cmd_op == dcp_pkg::CT_CLRBF));

  ////////////////////////////////////////////////////////////////////
  // Sticky error events; a new event wins over the clear
  assign ev = {EV_DRIVE_ERR, EV_BUF_LATE, EV_HDR_MISSING,
               EV_TIMEOUT, EV_HDR_ECC, EV_DATA_ECC};

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      flg_ff <= 6'h00;
    else
      flg_ff <= (flg_ff & ~{6{clr_all}}) | ev;
  end

  ////////////////////////////////////////////////////////////////////
  // ECC comparison code
  always_comb
  begin
    if (!ECC_ANY_ERR)
      nxt_ecc = dcp_pkg::ECC_NONE;
    else if (ECC_CORR)
      nxt_ecc = dcp_pkg::ECC_CORR;
    else if (ECC_NONCORR)
      nxt_ecc = dcp_pkg::ECC_NCORR;
    else
      nxt_ecc = dcp_pkg::ECC_DATA;
  end

  // A finishing comparison wins over a clear
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      ecc_ff <= dcp_pkg::ECC_NONE;
    else if (ECC_DONE)
      ecc_ff <= nxt_ecc;
    else if (clr_all)
      ecc_ff <= dcp_pkg::ECC_NONE;
  end

  ////////////////////////////////////////////////////////////////////
  // Status word; each error bit is the OR of the events that imply it
  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[dcp_pkg::SW_OPINC] = flg_ff[1] | flg_ff[2]
                                 | flg_ff[3];
    stat_word[dcp_pkg::SW_DCHK]  = flg_ff[0] | flg_ff[1];
    stat_word[dcp_pkg::SW_DLATE] = flg_ff[3] | flg_ff[4];
    stat_word[dcp_pkg::SW_DRVE]  = flg_ff[5];
    stat_word[dcp_pkg::SW_COMP]  = |flg_ff;
    stat_word[dcp_pkg::SW_ECCHI] = ecc_ff[1];
    stat_word[dcp_pkg::SW_ECCLO] = ecc_ff[0];
  end

  ////////////////////////////////////////////////////////////////////
  // Drive status capture; sector count is frozen at the sample
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      cart0_ff <= 8'h00;
      cart1_ff <= 8'h00;
      fix0_ff  <= 8'h00;
      fix1_ff  <= 8'h00;
    end
    else if (STATUS_SAMPLE)
    begin
      cart0_ff <= {1'b0, HEAD_SEL, COVER_OPEN, HEADS_OUT,
                   BRUSHES_HOME, CART_STATE};
      cart1_ff <= {WRITE_DATA_MISSING, STRAY_WRITE_CURRENT,
                   WRITE_LOCKED, SEEK_TIMEOUT,
                   SPINDLE_ERR, WRITE_GATE_ERR,
                   VOLUME_CHANGED, MULTI_SELECT_ERR};
      fix0_ff  <= {3'h0, SECTOR_COUNT};
      fix1_ff  <= {2'h0, WRITE_PROTECTED, DRIVE_READY, ON_CYLINDER,
                   SEEK_ERR, ADDR_PLUG_VALID, DRIVE_FAULT};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Byte pointer: successive byte reads give byte one then two
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      byte_ptr_ff <= 1'b0;
    else if (clr_ptr)
      byte_ptr_ff <= 1'b0;
    else if (rd_cmd && cmd_op == dcp_pkg::RD_BYTE)
      byte_ptr_ff <= ~byte_ptr_ff;
  end

  ////////////////////////////////////////////////////////////////////
  // Word staged by a read command
  always_comb
  begin
    nxt_word = 32'h0000_0000;
    unique case (cmd_op)
      dcp_pkg::RD_STAT: nxt_word = stat_word;
      dcp_pkg::RD_ADDR: nxt_word = DISK_ADDR;
      dcp_pkg::RD_BYTE:
        // Byte chosen by drive type and pointer
        unique case ({fixed_ff, byte_ptr_ff})
          2'h0: nxt_word[7:0] = cart0_ff;
          2'h1: nxt_word[7:0] = cart1_ff;
          2'h2: nxt_word[7:0] = fix0_ff;
          2'h3: nxt_word[7:0] = fix1_ff;
        endcase
      dcp_pkg::RD_WORD: nxt_word = BUF_WORD;
      dcp_pkg::RD_PAT:  nxt_word[12:0] = ERR_PATTERN;
      dcp_pkg::RD_POS:  nxt_word[12:0] = ERR_POSITION;
      default:          nxt_word = 32'h0000_0000; // Unused codes
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      word_ff <= 32'h0000_0000;
    else if (rd_cmd)
      word_ff <= nxt_word;
  end

  ////////////////////////////////////////////////////////////////////
  // Read strobe answer; accelerator reads leave the lines to it
  assign rd_req = READ_PORT & ~ACCEL_SELECT;

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      CPU_RDATA    <= 32'h0000_0000;
      CPU_RDATA_OE <= 1'b0;
    end
    else
    begin
      CPU_RDATA    <= rd_req ? word_ff : 32'h0000_0000;
      CPU_RDATA_OE <= rd_req;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register port: control write, status read one cycle later
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      fixed_ff <= dcp_pkg::CTRL_RST;
    else if (REG_WR && REG_ADDR == dcp_pkg::REG_CTRL)
      fixed_ff <= REG_WDATA[dcp_pkg::CTRL_FIX];
  end

  // Unmapped offsets read zero
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      REG_RDATA <= 32'h0000_0000;
    else if (REG_RD && REG_ADDR == dcp_pkg::REG_CTRL)
      REG_RDATA <= {31'h0000_0000, fixed_ff};
    else if (REG_RD && REG_ADDR == dcp_pkg::REG_STAT)
      REG_RDATA <= stat_word;
    else
      REG_RDATA <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  assign err5 = {stat_word[dcp_pkg::SW_COMP], stat_word[dcp_pkg::SW_DRVE],
                 stat_word[dcp_pkg::SW_DLATE], stat_word[dcp_pkg::SW_DCHK],
                 stat_word[dcp_pkg::SW_OPINC]};

  sequence quiet_s;
    flg_ff == 6'h00 && !clr_all;
  endsequence

  sequence read_req_s;
    READ_PORT && !ACCEL_SELECT;
  endsequence

  data_field_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    quiet_s and (ev == 6'h01) |=> err5 == 5'h12)
    else $error("data field error pattern wrong");

  hdr_field_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    quiet_s and (ev == 6'h02) |=> err5 == 5'h13)
    else $error("header field error pattern wrong");

  hdr_missing_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    quiet_s and (ev == 6'h08) |=> err5 == 5'h15)
    else $error("header missing pattern wrong");

  buf_late_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    quiet_s and (ev == 6'h10) |=> err5 == 5'h14)
    else $error("data late pattern wrong");

  drive_err_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    quiet_s and (ev == 6'h20) |=> err5 == 5'h18)
    else $error("drive error pattern wrong");

  ecc_corr_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    ECC_DONE && ECC_ANY_ERR && ECC_CORR |=>
      stat_word[dcp_pkg::SW_ECCHI] && stat_word[dcp_pkg::SW_ECCLO])
    else $error("correctable ecc code wrong");

  composite_or_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    err5[4] == |err5[3:0])
    else $error("composite bit not the OR");

  cmd_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $changed(word_ff) |-> $past(CMD_STROBE && DEV_SELECT_BIT))
    else $error("word staged without strobe and select");

  read_answer_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    read_req_s |=> CPU_RDATA_OE && CPU_RDATA == $past(word_ff))
    else $error("read strobe not answered");

  accel_quiet_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    ACCEL_SELECT |=> !CPU_RDATA_OE)
    else $error("port drove during accelerator read");

  nop_cmd_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    cmd_take && cmd_id == dcp_pkg::ID_NOP |=>
      $stable(word_ff) && $stable(byte_ptr_ff))
    else $error("no-operation changed state");

  fixed_pad_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    STATUS_SAMPLE |=> fix0_ff == {3'h0, $past(SECTOR_COUNT)})
    else $error("sector count not captured");

endmodule : dcp_cpu_port

`default_nettype wire

// *** test/dcp_cpu_seq.sv ***
/*
  Model of the CPU microcode sequencer that issues port commands.
  Assumes one clock shared with the port and dcp_pkg compiled first.
*/
`default_nettype none

module dcp_cpu_seq (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       req,
  input  wire logic       req_sel,
  input  wire logic [4:0] req_field,
  output logic            done,
  output logic            strobe,
  output logic            dev_sel,
  output logic      [4:0] field,
  output logic            phase2
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int MC = dcp_pkg::MICROCYCLE_CYC;
  int   cnt;   // Position inside the microcycle
  logic pend;  // Request waiting for the next microcycle

  //////////////////////////////////////////////////////////////////////
  // Free running microcycle, phase-2 high in its last window
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt <= 0;
    else
      cnt <= (cnt == MC - 1) ? 0 : cnt + 1;
  end
  assign phase2 = rst_n && (cnt >= MC - dcp_pkg::PHASE2_CYC);

  //////////////////////////////////////////////////////////////////////
  // Command held for one whole microcycle; idle lines wander so that
  // a port that ignores the strobe would pick up garbage
  always_ff @(posedge clk)
  begin
    done <= 1'b0;
    if (!rst_n)
    begin
      strobe  <= 1'b0;
      dev_sel <= 1'b0;
      field   <= '0;
      pend    <= 1'b0;
    end
    else if (cnt == MC - 1 && (pend || req))
    begin
      strobe  <= 1'b1;
      dev_sel <= req_sel;
      field   <= req_field;
      pend    <= 1'b0;
    end
    else if (cnt == MC - 1)
    begin
      done    <= strobe;
      strobe  <= 1'b0;
      dev_sel <= ~dev_sel;
      field   <= ~field;
    end
    else if (req)
      pend <= 1'b1;
  end
endmodule : dcp_cpu_seq

`default_nettype wire

// *** test/dcp_cpu_port_tb.sv ***
/*
  Self-checking bench for the disk controller CPU port.
  Assumes dcp_pkg, dcp_cpu_port and dcp_cpu_seq compiled first.
*/
`default_nettype none

module dcp_cpu_port_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic MCLK, RST_N, READ_PORT, ACCEL_SELECT, CPU_RDATA_OE, ECC_DONE;
  logic STATUS_SAMPLE, REG_WR, REG_RD, CMD_STROBE, DEV_SELECT_BIT;
  logic GATED_PHASE2_CLK, c_req, c_sel, c_done, rd_d;
  logic [4:0]  CMD_FIELD, c_field;
  logic [3:0]  REG_ADDR;
  logic [5:0]  ev;    // Error event pulses
  logic [2:0]  ecc;   // {corr, noncorr, any}
  logic [25:0] drv;   // Drive status levels
  logic [31:0] CPU_RDATA, REG_RDATA, REG_WDATA, src[4], seed;
  logic [63:0] cq[$], rq[$];  // {mask, expected}
  int fails, check_count;
  localparam logic [31:0] SMASK = 32'h0030_DC00;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;

  dcp_cpu_seq u_seq (.clk(MCLK), .rst_n(RST_N), .req(c_req),
    .req_sel(c_sel), .req_field(c_field), .done(c_done),
    .strobe(CMD_STROBE), .dev_sel(DEV_SELECT_BIT), .field(CMD_FIELD),
    .phase2(GATED_PHASE2_CLK));

  dcp_cpu_port u_dut (.MCLK(MCLK), .RST_N(RST_N),
    .CMD_STROBE(CMD_STROBE), .DEV_SELECT_BIT(DEV_SELECT_BIT),
    .CMD_FIELD(CMD_FIELD), .GATED_PHASE2_CLK(GATED_PHASE2_CLK),
    .READ_PORT(READ_PORT), .ACCEL_SELECT(ACCEL_SELECT),
    .CPU_RDATA(CPU_RDATA), .CPU_RDATA_OE(CPU_RDATA_OE),
    .EV_DATA_ECC(ev[0]), .EV_HDR_ECC(ev[1]), .EV_TIMEOUT(ev[2]),
    .EV_HDR_MISSING(ev[3]), .EV_BUF_LATE(ev[4]), .EV_DRIVE_ERR(ev[5]),
    .ECC_DONE(ECC_DONE), .ECC_ANY_ERR(ecc[0]), .ECC_NONCORR(ecc[1]),
    .ECC_CORR(ecc[2]), .DISK_ADDR(src[0]), .BUF_WORD(src[1]),
    .ERR_PATTERN(src[2][12:0]), .ERR_POSITION(src[3][12:0]),
    .STATUS_SAMPLE(STATUS_SAMPLE), .CART_STATE(drv[2:0]),
    .BRUSHES_HOME(drv[3]), .HEADS_OUT(drv[4]), .COVER_OPEN(drv[5]),
    .HEAD_SEL(drv[6]), .MULTI_SELECT_ERR(drv[7]),
    .VOLUME_CHANGED(drv[8]), .WRITE_GATE_ERR(drv[9]),
    .SPINDLE_ERR(drv[10]), .SEEK_TIMEOUT(drv[11]),
    .WRITE_LOCKED(drv[12]), .STRAY_WRITE_CURRENT(drv[13]),
    .WRITE_DATA_MISSING(drv[14]), .SECTOR_COUNT(drv[19:15]),
    .DRIVE_FAULT(drv[20]), .ADDR_PLUG_VALID(drv[21]),
    .SEEK_ERR(drv[22]), .ON_CYLINDER(drv[23]), .DRIVE_READY(drv[24]),
    .WRITE_PROTECTED(drv[25]), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA));

  //////////////////////////////////////////////////////////////////////
  // Clock, 25 ns period
  initial
  begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end

  // Error flags {composite, drive, late, check, incomplete} to word
  function automatic logic [31:0] sw(input logic [4:0] p);
    return {16'h0000, p[4], p[3], 1'b0, p[2], p[1], p[0], 10'h000};
  endfunction : sw

  task automatic cmp(input string what, input logic [63:0] n,
                     input logic [31:0] got);
    check_count++;
    if ((got & n[63:32]) !== (n[31:0] & n[63:32]))
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, n[31:0], got);
    end
  endtask : cmp

  task automatic cmp_cpu(input logic [63:0] n);
    cmp("cpu_rdata", n, CPU_RDATA);
  endtask : cmp_cpu

  task automatic cmp_reg(input logic [63:0] n);
    cmp("reg_rdata", n, REG_RDATA);
  endtask : cmp_reg

  //////////////////////////////////////////////////////////////////////
  // Result watcher: oldest note against each answer
  always @(posedge MCLK)
  begin
    if (rd_d)
      cmp_reg(rq.pop_front());
    rd_d = REG_RD;
    if (RST_N && CPU_RDATA_OE === 1'b1)
    begin
      if (cq.size() == 0)
      begin
        fails++;
        $display("ERROR cpu_rdata_oe expected 0 seen 1");
      end
      else
        cmp_cpu(cq.pop_front());
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Drivers
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    rq.push_back({m, e});
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
  endtask : reg_rd

  task automatic cmd(input logic s, input logic [4:0] f);
    int n;
    n = 0;
    @(posedge MCLK);
    c_sel <= s;
    c_field <= f;
    c_req <= 1'b1;
    @(posedge MCLK);
    c_req <= 1'b0;
    while (c_done !== 1'b1 && n < 40)
    begin
      @(posedge MCLK);
      n++;
    end
    if (n >= 40)
    begin
      fails++;
      $display("ERROR command_done expected 1 seen 0");
    end
  endtask : cmd

  task automatic port_rd(input logic acc, input logic [31:0] e,
                         input logic [31:0] m);
    if (!acc)
      cq.push_back({m, e});
    @(posedge MCLK);
    ACCEL_SELECT <= acc;
    READ_PORT <= 1'b1;
    @(posedge MCLK);
    READ_PORT <= 1'b0;
    ACCEL_SELECT <= 1'b0;
    repeat (2) @(posedge MCLK);
  endtask : port_rd

  task automatic rd(input logic [2:0] op, input logic [31:0] e,
                    input logic [31:0] m);
    cmd(1'b1, {dcp_pkg::ID_READ, op});
    port_rd(1'b0, e, m);
  endtask : rd

  task automatic pulse(input logic [5:0] v, input logic ed,
                       input logic ss);
    @(posedge MCLK);
    ev <= v;
    ECC_DONE <= ed;
    STATUS_SAMPLE <= ss;
    @(posedge MCLK);
    ev <= '0;
    ECC_DONE <= 1'b0;
    STATUS_SAMPLE <= 1'b0;
  endtask : pulse

  task automatic report_and_stop;
    // An answer that never came leaves its note behind
    if (cq.size() != 0 || rq.size() != 0)
    begin
      fails++;
      $display("ERROR pending_answers expected 0 seen %0d",
               cq.size() + rq.size());
    end
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Hang guard, far beyond the less than one thousand cycles of the sequence
  initial
  begin
    repeat (20000) @(posedge MCLK);
    fails++;
    report_and_stop();
  end

  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [4:0]  pat[6];
    logic [2:0]  ein[4];
    logic [25:0] d;
    pat = '{5'b10010, 5'b10011, 5'b10001, 5'b10101, 5'b10100, 5'b11000};
    ein = '{3'b000, 3'b001, 3'b011, 3'b101};
    seed = 32'h5d08;
    {RST_N, READ_PORT, ACCEL_SELECT, ECC_DONE, STATUS_SAMPLE} = '0;
    {REG_WR, REG_RD, c_req, c_sel, rd_d} = '0;
    {c_field, REG_ADDR, ev, ecc, REG_WDATA} = '0;
    drv = $random(seed);
    foreach (src[i]) src[i] = $random(seed);
    fails = 0;
    check_count = 0;
    repeat (10) @(posedge MCLK);
    RST_N <= 1'b1;
    reg_rd(dcp_pkg::REG_CTRL, 32'h0, ALL);
    reg_rd(4'hC, 32'h0, ALL);
    for (int i = 0; i < 6; i++)
    begin
      pulse(6'(1 << i), 1'b0, 1'b0);
      reg_rd(dcp_pkg::REG_STAT, sw(pat[i]), SMASK);
      cmd(1'b1, {dcp_pkg::ID_CTRL, dcp_pkg::CT_CLRALL});
    end
    pulse(6'b100000, 1'b0, 1'b0);
    cmd(1'b0, {dcp_pkg::ID_CTRL, dcp_pkg::CT_CLRALL});
    cmd(1'b1, {dcp_pkg::ID_NOP, dcp_pkg::CT_CLRALL});
    rd(dcp_pkg::RD_STAT, sw(pat[5]), SMASK);
    cmd(1'b1, {dcp_pkg::ID_CTRL, dcp_pkg::CT_CLRALL});
    for (int k = 0; k < 4; k++)
    begin
      ecc <= ein[k];
      pulse(6'h00, 1'b1, 1'b0);
      reg_rd(dcp_pkg::REG_STAT, {10'h000, k[0], k[1], 20'h0_0000}, SMASK);
    end
    port_rd(1'b1, 32'h0, 32'h0);
    rd(dcp_pkg::RD_ADDR, src[0], ALL);
    rd(dcp_pkg::RD_WORD, src[1], ALL);
    rd(dcp_pkg::RD_PAT, src[2], 32'h0000_1FFF);
    rd(dcp_pkg::RD_POS, src[3], 32'h0000_1FFF);
    for (int it = 0; it < 6; it++)
    begin
      reg_wr(dcp_pkg::REG_CTRL, 32'(it % 2));
      reg_rd(dcp_pkg::REG_CTRL, 32'(it % 2), 32'h0000_0001);
      pulse(6'h00, 1'b0, 1'b1);
      d = drv;
      drv <= $random(seed);
      cmd(1'b1, {dcp_pkg::ID_CTRL, dcp_pkg::CT_CLRBF});
      if (it % 2 == 0)
      begin
        rd(dcp_pkg::RD_BYTE, {25'h0, d[6:0]}, ALL);
        rd(dcp_pkg::RD_BYTE, {24'h0, d[14:7]}, ALL);
      end
      else
      begin
        rd(dcp_pkg::RD_BYTE, {27'h0, d[19:15]}, ALL);
        rd(dcp_pkg::RD_BYTE, {26'h0, d[25:20]}, ALL);
      end
    end
    repeat (4) @(posedge MCLK);
    report_and_stop();
  end
endmodule : dcp_cpu_port_tb

`default_nettype wire
